// *** design/crosspoint_route_config.sv ***
// crosspoint switch routing, double-buffered route latches and monitor port
//
// Function
// - disable bit latched with source, tristates output
// - six-bit source index picks mux input
// - channel select picks holding latch loaded
// - load strobe pulse writes holding latch
// - flow-through commit reaches outputs within limit; code takes four clock edges from the strobe pin, past COMMIT_MAX_PS
// - monitor bus settles within limit of strobe; code takes three clock edges from the strobe pin, past MONITOR_MAX_PS
// - monitor bus idles low after strobe falls
// - commit strobe copies all holding latches together
// - mode select high clocked, low flow-through
// - monitor shows selected route while strobe high
// - monitor select picks channel observed
`timescale 1ns/1ps
`default_nettype none
module crosspoint_route_config (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	// configuration pins
	input wire logic [5:0] source_select_in,
	input wire logic output_disable_in,
	input wire logic [5:0] channel_select_in,
	input wire logic load_strobe_in,
	input wire logic commit_strobe_in,
	input wire logic clocked_mode_select_in,
	// monitor pins
	input wire logic [5:0] monitor_select_in,
	input wire logic monitor_strobe_in,
	output logic [6:0] monitor_bus_out,
	output logic monitor_route_out,
	// switch data
	input wire logic [63:0] switch_inputs_in,
	output logic [63:0] switch_outputs_out,
	output logic [63:0] switch_outputs_oe_out,
	// register bus
	input wire xpoint_pkg::axil_req_type axil_req_in,
	output xpoint_pkg::axil_rsp_type axil_rsp_out
);
	// assertion clock and reset for the whole block
	default clocking assert_clk @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_b_in);
	// pin capture and synchronised fields
	logic [86:0] pin_meta_q;
	logic [86:0] pin_sync_q;
	logic [1:0] strobe_prev_q;
	logic [63:0] in_reg_q;
	wire [86:0] pin_raw = {switch_inputs_in, source_select_in,
		output_disable_in, channel_select_in, load_strobe_in,
		commit_strobe_in, clocked_mode_select_in, monitor_select_in,
		monitor_strobe_in};
	wire [63:0] in_s = pin_sync_q[86:23];
	wire [5:0] src_s = pin_sync_q[22:17];
	wire dis_s = pin_sync_q[16];
	wire [5:0] chan_s = pin_sync_q[15:10];
	wire load_s = pin_sync_q[9];
	wire commit_s = pin_sync_q[8];
	wire mode_s = pin_sync_q[7];
	wire [5:0] mon_sel_s = pin_sync_q[6:1];
	wire mon_s = pin_sync_q[0];
	// two-flop synchronisers for all pin inputs
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
			strobe_prev_q <= 2'h0;
			in_reg_q <= 64'h0;
		end else begin
			pin_meta_q <= pin_raw;
			pin_sync_q <= pin_meta_q;
			strobe_prev_q <= {load_s, commit_s};
			in_reg_q <= in_s;
		end
	end
	// control register from the bus gates the load and commit strobes
	logic [31:0] ctrl_q;
	logic [15:0] commit_cnt_q;
	logic [15:0] load_cnt_q;
	wire strobe_en = ctrl_q[xpoint_pkg::CTRL_STROBE_EN_POS];
	wire load_pulse = load_s && !strobe_prev_q[1] && strobe_en;
	wire commit_pulse = commit_s && !strobe_prev_q[0] && strobe_en;
	// clocked mode adds an input register stage
	wire [63:0] data_sel = mode_s ? in_reg_q : in_s;
	// holding and control latches
	xpoint_pkg::route_type hold_q [64];
	xpoint_pkg::route_type ctrl_rt_q [64];
	wire xpoint_pkg::route_type new_route = '{disable_out: dis_s,
		src: src_s};
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			for (int i = 0; i < xpoint_pkg::CHANNELS; i++) begin
				hold_q[i] <= xpoint_pkg::ROUTE_RST;
				ctrl_rt_q[i] <= xpoint_pkg::ROUTE_RST;
			end
		end else begin
			if (load_pulse) begin
				hold_q[chan_s] <= new_route;
			end
			if (commit_pulse) begin
				for (int i = 0; i < xpoint_pkg::CHANNELS; i++) begin
					ctrl_rt_q[i] <= hold_q[i];
				end
			end
		end
	end
	// switch outputs follow control registers every cycle
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			switch_outputs_out <= 64'h0;
			switch_outputs_oe_out <= 64'h0;
		end else begin
			for (int i = 0; i < xpoint_pkg::CHANNELS; i++) begin
				switch_outputs_out[i] <= data_sel[ctrl_rt_q[i].src];
				switch_outputs_oe_out[i] <= !ctrl_rt_q[i].disable_out;
			end
		end
	end
	// monitor read-back, all low while strobe is low
	wire xpoint_pkg::route_type mon_route = ctrl_rt_q[mon_sel_s];
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			monitor_bus_out <= 7'h00;
			monitor_route_out <= 1'b0;
		end else begin
			monitor_bus_out <= mon_s ? mon_route : 7'h00;
			monitor_route_out <= mon_s && data_sel[mon_route.src];
		end
	end
	// bus decode
	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic arready_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic [7:0] waddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	wire aw_take = axil_req_in.awvalid && axil_rsp_out.awready;
	wire w_take = axil_req_in.wvalid && axil_rsp_out.wready;
	wire wr_go = !axil_rsp_out.awready && !axil_rsp_out.wready &&
		!axil_rsp_out.bvalid;
	wire wr_ctrl = waddr_q == xpoint_pkg::CTRL_OFS;
	wire ar_take = axil_req_in.arvalid && axil_rsp_out.arready;
	wire rd_ctrl = axil_req_in.araddr == xpoint_pkg::CTRL_OFS;
	wire rd_stat = axil_req_in.araddr == xpoint_pkg::STAT_OFS;
	wire [31:0] stat_word = {load_cnt_q, commit_cnt_q};
	wire [31:0] rd_word = rd_ctrl ? ctrl_q : (rd_stat ? stat_word : 32'h0);
	// event counters and control register
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ctrl_q <= xpoint_pkg::CTRL_RST;
			commit_cnt_q <= xpoint_pkg::COUNT_RST;
			load_cnt_q <= xpoint_pkg::COUNT_RST;
		end else begin
			if (wr_go && wr_ctrl && wstrb_q[0]) begin
				ctrl_q <= {31'h0, wdata_q[xpoint_pkg::CTRL_STROBE_EN_POS]};
			end
			if (commit_pulse) begin
				commit_cnt_q <= commit_cnt_q + 16'h0001;
			end
			if (load_pulse) begin
				load_cnt_q <= load_cnt_q + 16'h0001;
			end
		end
	end
	// write channels
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			waddr_q <= 8'h00;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= xpoint_pkg::RESP_OKAY;
		end else begin
			if (aw_take) begin
				waddr_q <= axil_req_in.awaddr;
				awready_q <= 1'b0;
			end
			if (w_take) begin
				wdata_q <= axil_req_in.wdata;
				wstrb_q <= axil_req_in.wstrb;
				wready_q <= 1'b0;
			end
			if (wr_go) begin
				bvalid_q <= 1'b1;
				bresp_q <= (wr_ctrl || waddr_q ==
					xpoint_pkg::STAT_OFS) ? xpoint_pkg::RESP_OKAY :
					xpoint_pkg::RESP_SLVERR;
			end
			if (bvalid_q && axil_req_in.bready) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end
	// read channels
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= xpoint_pkg::RESP_OKAY;
		end else begin
			if (ar_take) begin
				arready_q <= 1'b0;
				rvalid_q <= 1'b1;
				rdata_q <= rd_word;
				rresp_q <= (rd_ctrl || rd_stat) ?
					xpoint_pkg::RESP_OKAY : xpoint_pkg::RESP_SLVERR;
			end
			if (rvalid_q && axil_req_in.rready) begin
				rvalid_q <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end
	// response bundle straight from the channel flops
	assign axil_rsp_out = '{awready: awready_q, wready: wready_q,
		bvalid: bvalid_q, bresp: bresp_q, arready: arready_q,
		rvalid: rvalid_q, rdata: rdata_q, rresp: rresp_q};
	// checks on the routing logic and the bus write response
	load_write_a: assert property (
		load_pulse |=> hold_q[$past(chan_s)] == $past(new_route))
		else $error("holding latch not written by load");
	commit_copy_a: assert property (
		commit_pulse |=> ctrl_rt_q[0] == $past(hold_q[0]) &&
		ctrl_rt_q[63] == $past(hold_q[63]))
		else $error("commit did not copy all routes");
	route_hold_a: assert property (
		!commit_pulse |=> $stable(ctrl_rt_q[5]))
		else $error("route changed without commit");
	commit_latency_a: assert property (
		commit_pulse |-> ##2 switch_outputs_oe_out[0] ==
		!$past(hold_q[0].disable_out, 2))
		else $error("committed enable late at output");
	out_enable_a: assert property (
		1'b1 |=> switch_outputs_oe_out[3] == !$past(ctrl_rt_q[3].disable_out))
		else $error("output enable mismatches disable bit");
	flow_data_a: assert property (
		!mode_s |=> switch_outputs_out[0] == $past(in_s[ctrl_rt_q[0].src]))
		else $error("flow-through output not routed input");
	clocked_data_a: assert property (
		mode_s |=> switch_outputs_out[0] == $past(in_reg_q[ctrl_rt_q[0].src]))
		else $error("clocked output not registered input");
	monitor_show_a: assert property (
		mon_s |=> monitor_bus_out == $past(mon_route))
		else $error("monitor bus not showing route");
	monitor_idle_a: assert property (
		$fell(mon_s) |=> monitor_bus_out == 7'h00 && !monitor_route_out)
		else $error("monitor bus not idle after strobe");
	bvalid_hold_a: assert property (
		axil_rsp_out.bvalid && !axil_req_in.bready |=> axil_rsp_out.bvalid)
		else $error("write response dropped early");
	load_seen_c: cover property (load_pulse ##[1:20] commit_pulse);
	monitor_seen_c: cover property (mon_s [*2] ##1 !mon_s);
	bus_write_c: cover property (axil_rsp_out.bvalid && axil_req_in.bready);
endmodule // crosspoint_route_config
`default_nettype wire

// *** design/xpoint_pkg.sv ***
// shared constants and carrier types for the crosspoint route configuration
package xpoint_pkg;
	localparam int CHANNELS = 64;
	localparam int SEL_W = 6;
	// clock period and pin timing, in picoseconds
	localparam int CLK_PERIOD_PS = 5000;
	localparam int STROBE_MIN_PS = 5000;
	localparam int STROBE_MIN_CYC = (STROBE_MIN_PS + CLK_PERIOD_PS - 1) /
		CLK_PERIOD_PS;
	localparam int MONITOR_MIN_PS = 10000;
	localparam int MONITOR_MIN_CYC = (MONITOR_MIN_PS + CLK_PERIOD_PS - 1) /
		CLK_PERIOD_PS;
	localparam int COMMIT_MAX_PS = 8500;
	localparam int COMMIT_MAX_CYC = COMMIT_MAX_PS / CLK_PERIOD_PS;
	localparam int MONITOR_MAX_PS = 10000;
	localparam int MONITOR_MAX_CYC = MONITOR_MAX_PS / CLK_PERIOD_PS;
	// register map
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam int CTRL_STROBE_EN_POS = 0;
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;
	localparam int STAT_COMMIT_LSB = 0;
	localparam int STAT_LOAD_LSB = 16;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// one channel's route: output disable over source index
	typedef struct packed {
		logic disable_out;
		logic [SEL_W-1:0] src;
	} route_type;
	localparam route_type ROUTE_RST = 7'h40;
	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} axil_req_type;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axil_rsp_type;
endpackage

// *** sim/xpoint_ctrl_model.sv ***
// configuration controller model driving the strobe pins
`timescale 1ns/1ps
`default_nettype none
module xpoint_ctrl_model (
	// clock and monitor readback
	input wire logic clk_in,
	input wire logic [6:0] monitor_bus_in,
	input wire logic monitor_route_in,
	// configuration pins
	output logic [5:0] source_select_out,
	output logic output_disable_out,
	output logic [5:0] channel_select_out,
	output logic load_strobe_out,
	output logic commit_strobe_out,
	output logic [5:0] monitor_select_out,
	output logic monitor_strobe_out
);
	// idle with all strobes low
	initial begin
		{source_select_out, output_disable_out, channel_select_out} = '0;
		{load_strobe_out, commit_strobe_out, monitor_strobe_out} = 3'h0;
		monitor_select_out = 6'h00;
	end
	// strobe two cycles, buses inverted once their hold runs out
	task automatic load(input logic [5:0] ch, sr, input logic dis);
		@(posedge clk_in);
		channel_select_out <= ch;
		source_select_out <= sr;
		output_disable_out <= dis;
		load_strobe_out <= 1'b1;
		repeat (2) @(posedge clk_in);
		load_strobe_out <= 1'b0;
		repeat (2) @(posedge clk_in);
		channel_select_out <= ~ch;
		source_select_out <= ~sr;
		output_disable_out <= ~dis;
		repeat (2) @(posedge clk_in);
	endtask
	// commit only between loads, never overlapping one
	task automatic commit();
		@(posedge clk_in);
		commit_strobe_out <= 1'b1;
		repeat (2) @(posedge clk_in);
		commit_strobe_out <= 1'b0;
		repeat (4) @(posedge clk_in);
	endtask
	// readback: sample while high, then after the fall
	task automatic monitor(input logic [5:0] ch, output logic [6:0] on,
		output logic rt, output logic [6:0] off);
		@(posedge clk_in);
		monitor_select_out <= ch;
		monitor_strobe_out <= 1'b1;
		repeat (4) @(posedge clk_in);
		on = monitor_bus_in;
		rt = monitor_route_in;
		monitor_strobe_out <= 1'b0;
		repeat (4) @(posedge clk_in);
		off = monitor_bus_in;
		monitor_select_out <= ~ch;
	endtask
endmodule // xpoint_ctrl_model
`default_nettype wire

// *** sim/crosspoint_route_config_tb.sv ***
// self-checking bench for the crosspoint route configuration
`timescale 1ns/1ps
`default_nettype none
module crosspoint_route_config_tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic mode = 1'b0;
	logic [63:0] din = '0;
	xpoint_pkg::axil_req_type req = '0;
	xpoint_pkg::axil_rsp_type rsp;
	logic [5:0] src, ch, msel;
	logic dis, ld, cm, ms, mrt, rt;
	logic [6:0] mbus, on, off;
	logic [63:0] dout, oe;
	logic [31:0] rd;
	logic [1:0] rr;
	int num_errors = 0;
	int checks = 0;
	int cyc = 0;
	always #2.5 clk = ~clk;
	crosspoint_route_config u_crosspoint_route_config (.ref_clk_in(clk),
		.rst_b_in(rst_b), .source_select_in(src), .output_disable_in(dis),
		.channel_select_in(ch), .load_strobe_in(ld), .commit_strobe_in(cm),
		.clocked_mode_select_in(mode), .monitor_select_in(msel),
		.monitor_strobe_in(ms), .monitor_bus_out(mbus),
		.monitor_route_out(mrt), .switch_inputs_in(din),
		.switch_outputs_out(dout), .switch_outputs_oe_out(oe),
		.axil_req_in(req), .axil_rsp_out(rsp));
	xpoint_ctrl_model u_xpoint_ctrl_model (.clk_in(clk),
		.monitor_bus_in(mbus), .monitor_route_in(mrt),
		.source_select_out(src), .output_disable_out(dis),
		.channel_select_out(ch), .load_strobe_out(ld),
		.commit_strobe_out(cm), .monitor_select_out(msel),
		.monitor_strobe_out(ms));
	// cycle ceiling against hangs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			num_errors++;
			results();
		end
	end
	// compare and count
	task automatic chk(input logic [63:0] got, exp, input string m);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	// bus write: both channels offered, bready held until bvalid
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do begin
			@(posedge clk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1);
		rr = rsp.bresp;
		req.bready <= 1'b0;
		@(posedge clk);
	endtask
	// bus read: rready held until rvalid
	task automatic axr(input logic [7:0] a);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do begin
			@(posedge clk);
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1);
		rd = rsp.rdata;
		rr = rsp.rresp;
		req.rready <= 1'b0;
		@(posedge clk);
	endtask
	// verdict
	task automatic results();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// test sequence
	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		chk(oe, 64'h0, "reset routes not disabled");
		din <= 64'h8000_0000_0000_0400;
		u_xpoint_ctrl_model.load(6'h05, 6'h0A, 1'b0);
		u_xpoint_ctrl_model.load(6'h3F, 6'h3F, 1'b0);
		u_xpoint_ctrl_model.load(6'h00, 6'h0A, 1'b1);
		chk(oe, 64'h0, "routes moved before commit");
		u_xpoint_ctrl_model.commit();
		repeat (2) @(posedge clk);
		chk(oe, 64'h8000_0000_0000_0020, "enables after commit");
		chk(dout & oe, 64'h8000_0000_0000_0020, "routed data");
		din <= 64'h7FFF_FFFF_FFFF_FBFF;
		repeat (6) @(posedge clk);
		chk(dout & oe, 64'h0, "routed data inverted");
		$display("test routing done");
		u_xpoint_ctrl_model.monitor(6'h05, on, rt, off);
		chk(64'(on), 64'h0A, "monitor route");
		chk(64'(rt), 64'h0, "monitor mux output");
		chk(64'(off), 64'h0, "monitor idle");
		u_xpoint_ctrl_model.monitor(6'h00, on, rt, off);
		chk(64'(on), 64'h4A, "monitor disabled route");
		$display("test monitor done");
		mode <= 1'b1;
		din <= 64'h8000_0000_0000_0400;
		repeat (8) @(posedge clk);
		chk(dout & oe, 64'h8000_0000_0000_0020, "clocked data");
		u_xpoint_ctrl_model.monitor(6'h3F, on, rt, off);
		chk(64'(on), 64'h3F, "monitor last channel");
		chk(64'(rt), 64'h1, "monitor mux output high");
		$display("test clocked done");
		axr(xpoint_pkg::STAT_OFS);
		chk(64'(rd), 64'h0003_0001, "strobe counts");
		axw(xpoint_pkg::CTRL_OFS, 32'h0000_0000);
		u_xpoint_ctrl_model.load(6'h05, 6'h3F, 1'b1);
		u_xpoint_ctrl_model.commit();
		axw(xpoint_pkg::CTRL_OFS, 32'h0000_0001);
		axr(xpoint_pkg::CTRL_OFS);
		chk(64'(rd), 64'h1, "control readback");
		chk(oe, 64'h8000_0000_0000_0020, "refused strobes acted");
		axw(xpoint_pkg::STAT_OFS, 32'hFFFF_FFFF);
		chk(64'(rr), 64'(xpoint_pkg::RESP_OKAY), "status write resp");
		axr(xpoint_pkg::STAT_OFS);
		chk(64'(rd), 64'h0003_0001, "status changed");
		axr(8'h08);
		chk(64'({rr, rd}), 64'h2_0000_0000, "unmapped read");
		$display("test register bus done");
		results();
	end
endmodule // crosspoint_route_config_tb
`default_nettype wire
